// File: hw/adc_map.svh
// Timing figures and field positions shared by both ends of the converter link.
// Assumes the system clock runs at the rate given by CLK_PERIOD_NS.
`ifndef ADC_MAP_SVH
`define ADC_MAP_SVH

`define CLK_PERIOD_NS       10
`define RESULT_W            16
`define RESULT_MSB          15
`define HIGH_BYTE_LSB       8
`define SIGN_FLIP           16'h8000
`define OE_FULL             16'hFFFF
`define OE_LOW_HALF         16'h00FF
`define CCLK_PERIOD_NS      100
`define CCLK_HALF_CYC       ((`CCLK_PERIOD_NS / 2 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONVERT_START_N_LOW_NS       20
`define CONVERT_START_N_LOW_CYC      ((`CONVERT_START_N_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_LOW_NS           80
`define RD_LOW_CYC          ((`RD_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_HIGH_NS          20
`define RD_HIGH_CYC         ((`RD_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FIFO_DEPTH          4

`endif

// File: hw/adc_pkg.sv
// Types shared by both ends of the converter link.
// Assumes adc_map.svh is on the include path.
`include "adc_map.svh"

package adc_pkg;
  typedef enum logic {DEV_IDLE, DEV_CONVERT} dev_state_e;
  typedef enum logic [2:0] {
    H_IDLE, H_SELECT, H_START, H_WAIT_RISE, H_WAIT_FALL, H_READ_HI, H_READ_LO, H_RELEASE
  } host_state_e;
  typedef logic [`RESULT_MSB:0] result_t;
endpackage : adc_pkg

// File: hw/adc_link_if.sv
// Pin-level link between the converter and its host controller.
// Both ends run on the same system clock; the pins still pass synchronisers.
`timescale 1ns/1ns
`default_nettype none

interface adc_link_if;
  logic        conv_clk;
  logic        convert_start_n;
  logic        cs_n;
  logic        rd_n;
  logic        byte_sel;
  logic        busy;
  logic [15:0] result_bus;
  logic [15:0] result_bus_oe;
  wire  [15:0] result_bus_pin;

  // Undriven bits read as zero, as if the board pulled them down.
  assign result_bus_pin = result_bus & result_bus_oe;

  modport dev (
    input  conv_clk, convert_start_n, cs_n, rd_n, byte_sel,
    output busy, result_bus, result_bus_oe
  );
  modport host (
    output conv_clk, convert_start_n, cs_n, rd_n, byte_sel,
    input  busy, result_bus_pin
  );
endinterface : adc_link_if

`default_nettype wire

// File: hw/adc_device_end.sv
// Converter end: successive-approximation control and parallel readout.
// Assumes every link pin may change at any time; all pass two flip-flops.
`timescale 1ns/1ns
`default_nettype none
`include "adc_map.svh"

module adc_device_end
  import adc_pkg::*;
(
  // System
  input  wire logic    clk,
  input  wire logic    rst_b,
  // Value the converter samples; stands in for the differential input
  input  wire result_t sample_in,
  // Link pins
  adc_link_if.dev      link
);

  // Synchroniser bit order within s1 and s2.
  localparam int P_CCLK = 4;
  localparam int P_CST  = 3;
  localparam int P_CS   = 2;
  localparam int P_RD   = 1;
  localparam int P_BYTE = 0;

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic       cclk_d;
    logic       cst_d;
    dev_state_e state;
    result_t    held;
    result_t    trial;
    result_t    mask;
    result_t    result;
    logic       busy;
    result_t    bus;
    result_t    bus_oe;
  } dev_s;

  dev_s r;
  dev_s n;

  logic cclk_rise;
  logic start_fall;
  logic cs_on;
  logic read_on;
  logic byte_hi;

  assign cclk_rise  = r.s2[P_CCLK] & ~r.cclk_d;
  assign start_fall = r.cst_d & ~r.s2[P_CST];
  assign cs_on      = ~r.s2[P_CS];
  assign read_on    = cs_on & ~r.s2[P_RD];
  assign byte_hi    = r.s2[P_BYTE];

  always_comb begin
    n        = r;
    n.s1     = {link.conv_clk, link.convert_start_n, link.cs_n, link.rd_n, link.byte_sel};
    n.s2     = r.s1;
    n.cclk_d = r.s2[P_CCLK];
    n.cst_d  = r.s2[P_CST];

    unique case (r.state)
      DEV_IDLE: begin
        // A start while chip select is high is ignored entirely.
        if (start_fall && cs_on) begin
          // Offset binary lets the search run unsigned; flipped back on latch.
          n.held  = sample_in ^ `SIGN_FLIP;
          n.trial = `SIGN_FLIP;
          n.mask  = `SIGN_FLIP;
          n.busy  = 1'b1;
          n.state = DEV_CONVERT;
        end
      end
      DEV_CONVERT: begin
        // Nothing advances between conversion clock edges, however slow.
        if (cclk_rise) begin
          if (r.mask != '0) begin
            if (r.trial > r.held) begin
              n.trial = (r.trial & ~r.mask) | (r.mask >> 1);
            end else begin
              n.trial = r.trial | (r.mask >> 1);
            end
            n.mask = r.mask >> 1;
          end else begin
            // Result and busy change on the same edge, so a read after busy
            // falls can never see the previous conversion.
            n.result = r.trial ^ `SIGN_FLIP;
            n.busy   = 1'b0;
            n.state  = DEV_IDLE;
          end
        end
      end
    endcase

    // The bus follows byte select while the strobe stays low; no new strobe needed.
    if (read_on) begin
      if (byte_hi) begin
        n.bus    = {8'h00, r.result[`RESULT_MSB:`HIGH_BYTE_LSB]};
        n.bus_oe = `OE_LOW_HALF;
      end else begin
        n.bus    = r.result;
        n.bus_oe = `OE_FULL;
      end
    end else begin
      n.bus_oe = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r        <= '0;
      r.s1     <= '1;
      r.s2     <= '1;
      r.cclk_d <= 1'b1;
      r.cst_d  <= 1'b1;
      r.state  <= DEV_IDLE;
    end else begin
      r <= n;
    end
  end

  assign link.busy          = r.busy;
  assign link.result_bus    = r.bus;
  assign link.result_bus_oe = r.bus_oe;

endmodule : adc_device_end

`default_nettype wire

// File: hw/adc_host_end.sv
// Host end: runs conversions, reads results and queues them for the user.
// Assumes the converter pins answer within the read low time set in adc_map.svh.
`timescale 1ns/1ns
`default_nettype none
`include "adc_map.svh"

module sync_fifo #(
  parameter int W = 16,
  parameter int D = 4
) (
  // System
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output var  logic         in_ready,
  // Drain side
  output var  logic         out_valid,
  output var  logic [W-1:0] out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic                valid;
    logic [W-1:0]        head;
  } fifo_s;

  fifo_s r;
  fifo_s n;
  logic  push;
  logic  pop;

  assign in_ready  = r.cnt != (AW + 1)'(D);
  // Both drain outputs are registered copies, so no logic sits between them and the user.
  assign out_valid = r.valid;
  assign out_data  = r.head;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = in_data;
      n.wp        = (r.wp == AW'(D - 1)) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (r.rp == AW'(D - 1)) ? '0 : r.rp + 1'b1;
    end
    n.cnt   = r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    n.valid = n.cnt != '0;
    n.head  = n.mem[n.rp];
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule : sync_fifo

module adc_host_end
  import adc_pkg::*;
(
  // System
  input  wire logic    clk,
  input  wire logic    rst_b,
  // Request: level; a new conversion starts whenever high and idle
  input  wire logic    conv_req,
  input  wire logic    byte_mode,
  // Results out of the queue
  output var  logic    result_valid,
  output var  result_t result_data,
  input  wire logic    result_ready,
  // Link pins
  adc_link_if.host     link
);

  typedef struct packed {
    logic [3:0]  div;
    logic        cclk;
    logic        busy_s1;
    logic        busy_s2;
    result_t     bus_s1;
    result_t     bus_s2;
    host_state_e state;
    logic [3:0]  cnt;
    logic        mode;
    result_t     word;
    logic        push;
    logic        cs_n;
    logic        cst_n;
    logic        rd_n;
    logic        byte_sel;
  } host_s;

  host_s r;
  host_s n;
  logic  fifo_in_ready;

  always_comb begin
    n         = r;
    n.busy_s1 = link.busy;
    n.busy_s2 = r.busy_s1;
    n.bus_s1  = link.result_bus_pin;
    n.bus_s2  = r.bus_s1;
    n.cnt     = (r.cnt != '0) ? r.cnt - 1'b1 : r.cnt;
    // Free-running conversion clock from a divider of the system clock.
    if (r.div == 4'(`CCLK_HALF_CYC - 1)) begin
      n.div  = '0;
      n.cclk = ~r.cclk;
    end else begin
      n.div = r.div + 1'b1;
    end
    // The push holds until the queue takes it; the read stays open meanwhile.
    if (r.push && fifo_in_ready) begin
      n.push  = 1'b0;
      n.rd_n  = 1'b1;
      n.cnt   = 4'(`RD_HIGH_CYC);
      n.state = H_RELEASE;
    end

    unique case (r.state)
      H_IDLE: begin
        if (conv_req) begin
          n.mode  = byte_mode;
          n.cs_n  = 1'b0;
          n.state = H_SELECT;
        end
      end
      H_SELECT: begin
        n.cst_n = 1'b0;
        n.cnt   = 4'(`CONVERT_START_N_LOW_CYC);
        n.state = H_START;
      end
      H_START: begin
        if (r.cnt == 4'h1) begin
          n.cst_n = 1'b1;
          n.state = H_WAIT_RISE;
        end
      end
      H_WAIT_RISE: begin
        if (r.busy_s2) begin
          n.state = H_WAIT_FALL;
        end
      end
      H_WAIT_FALL: begin
        if (!r.busy_s2) begin
          n.rd_n     = 1'b0;
          n.byte_sel = r.mode;
          n.cnt      = 4'(`RD_LOW_CYC);
          n.state    = r.mode ? H_READ_HI : H_READ_LO;
        end
      end
      H_READ_HI: begin
        if (r.cnt == 4'h1) begin
          n.word[`RESULT_MSB:`HIGH_BYTE_LSB] = r.bus_s2[7:0];
          // Second byte is fetched by flipping byte select under a held strobe.
          n.byte_sel = 1'b0;
          n.cnt      = 4'(`RD_LOW_CYC);
          n.state    = H_READ_LO;
        end
      end
      H_READ_LO: begin
        if (r.cnt == 4'h1 && !r.push) begin
          if (r.mode) begin
            n.word[7:0] = r.bus_s2[7:0];
          end else begin
            n.word = r.bus_s2;
          end
          n.push = 1'b1;
        end
      end
      H_RELEASE: begin
        // Chip select rises only after the strobe has risen.
        if (r.cnt == '0 && !r.push) begin
          n.cs_n  = 1'b1;
          n.state = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r         <= '0;
      r.cs_n    <= 1'b1;
      r.cst_n   <= 1'b1;
      r.rd_n    <= 1'b1;
      r.state   <= H_IDLE;
    end else begin
      r <= n;
    end
  end

  sync_fifo #(
    .W (`RESULT_W),
    .D (`FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (r.push),
    .in_data   (r.word),
    .in_ready  (fifo_in_ready),
    .out_valid (result_valid),
    .out_data  (result_data),
    .out_ready (result_ready)
  );

  assign link.conv_clk        = r.cclk;
  assign link.convert_start_n = r.cst_n;
  assign link.cs_n            = r.cs_n;
  assign link.rd_n            = r.rd_n;
  assign link.byte_sel        = r.byte_sel;

endmodule : adc_host_end

`default_nettype wire

// File: test/adc_link_chk.sv
// Pin checker for the converter link; sees the interface signals only.
// Assumes one system clock and a three-cycle pin-to-output lag in the converter.
`timescale 1ns/1ns
`default_nettype none

module adc_link_chk (
  // System
  input wire logic        clk,
  input wire logic        rst_b,
  // Link pins
  input wire logic        conv_clk,
  input wire logic        convert_start_n,
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic        byte_sel,
  input wire logic        busy,
  input wire logic [15:0] result_bus,
  input wire logic [15:0] result_bus_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Word and byte reads are judged after five steady cycles, a byte select swap four cycles after it falls, to clear the synchroniser lag.
  sequence s_word; (!cs_n && !rd_n && !byte_sel) [*5]; endsequence
  sequence s_byte; (!cs_n && !rd_n && byte_sel) [*5]; endsequence
  sequence s_swap; $fell(byte_sel) && !rd_n; endsequence

  logic [8:0] busy_cnt_r;

  always_ff @(posedge clk) begin
    if (!rst_b || !busy) busy_cnt_r <= 9'h000;
    else busy_cnt_r <= busy_cnt_r + 9'h001;
  end

  a_word_full_oe: assert property (s_word |-> result_bus_oe == 16'hFFFF)
    else $error("full word not driven");
  a_high_byte_oe: assert property (s_byte |-> result_bus_oe == 16'h00FF)
    else $error("high byte not on low half");
  a_swap_follows: assert property (s_swap |-> ##4 result_bus_oe == 16'hFFFF)
    else $error("byte select change not followed");
  a_busy_length: assert property ($fell(busy) |-> busy_cnt_r inside {[9'h09B:9'h0B9]})
    else $error("busy length off");
  a_busy_rise: assert property ($fell(convert_start_n) |-> ##[2:4] busy)
    else $error("busy did not rise");
  a_busy_fall_clk: assert property ($fell(busy) |-> conv_clk)
    else $error("busy fell outside conversion clock high");
  a_cs_before_start: assert property ($fell(convert_start_n) |-> !cs_n)
    else $error("start without chip select");
  a_rd_in_cs: assert property (!rd_n |-> !cs_n)
    else $error("read strobe outside chip select");
  a_oe_off_idle: assert property (cs_n [*4] |-> result_bus_oe == 16'h0000)
    else $error("bus driven while deselected");
  a_bus_hold: assert property (s_word |=> $stable(result_bus))
    else $error("result moved during read");
endmodule : adc_link_chk

`default_nettype wire

// File: test/tb_sar_adc_parallel_readout.sv
// Testbench: host end and converter end joined by the link, pin checker beside it.
// Assumes the design files and adc_pkg are compiled first.
`timescale 1ns/1ns
`default_nettype none

module tb_sar_adc_parallel_readout
  import adc_pkg::*;
;
  logic    clk          = 1'b0;
  logic    rst_b        = 1'b0;
  result_t sample_in    = 16'h8000;
  logic    conv_req     = 1'b0;
  logic    byte_mode    = 1'b0;
  logic    result_ready = 1'b1;
  logic    rnd_ready    = 1'b0;
  logic    result_valid;
  result_t result_data;
  int      failures     = 0;
  int      tests_run    = 0;
  result_t exp_q[$];

  always #5 clk = ~clk;

  adc_link_if link ();
  adc_device_end adc_device_end_i (.clk(clk), .rst_b(rst_b), .sample_in(sample_in), .link(link));
  adc_host_end adc_host_end_i (.clk(clk), .rst_b(rst_b), .conv_req(conv_req),
    .byte_mode(byte_mode), .result_valid(result_valid), .result_data(result_data),
    .result_ready(result_ready), .link(link));
  adc_link_chk adc_link_chk_i (.clk(clk), .rst_b(rst_b), .conv_clk(link.conv_clk),
    .convert_start_n(link.convert_start_n), .cs_n(link.cs_n), .rd_n(link.rd_n),
    .byte_sel(link.byte_sel), .busy(link.busy), .result_bus(link.result_bus),
    .result_bus_oe(link.result_bus_oe));

  task automatic check_word(input result_t got, input result_t exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic wait_busy(input logic lvl);
    for (int n = 0; link.busy !== lvl; n++) begin
      if (n == 3000) begin
        failures++;
        stop_test();
      end
      @(posedge clk);
      #1;
    end
  endtask : wait_busy

  task automatic wait_drained();
    for (int n = 0; exp_q.size() != 0; n++) begin
      if (n == 3000) begin
        failures++;
        stop_test();
      end
      @(posedge clk);
      #1;
    end
  endtask : wait_drained

  // The value is noted at busy rise and changed only after busy falls, so it is held.
  task automatic run_batch(input logic mode, input int n);
    byte_mode = mode;
    conv_req = 1'b1;
    for (int i = 0; i < n; i++) begin
      wait_busy(1'b1);
      exp_q.push_back(sample_in);
      if (i == n - 1) conv_req = 1'b0;
      wait_busy(1'b0);
      sample_in = (i == 0) ? 16'h7FFF : 16'($urandom);
    end
  endtask : run_batch

  always @(posedge clk) begin
    if (result_valid === 1'b1 && result_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("Error at %0t: got %h expected none", $time, result_data);
      end else begin
        check_word(result_data, exp_q.pop_front());
      end
    end
  end

  always @(posedge clk) begin
    if (rnd_ready) result_ready <= #1 1'($urandom % 2);
  end

  initial begin
    void'($urandom(54235));
    repeat (6) @(posedge clk);
    #1 rst_b = 1'b1;
    run_batch(1'b0, 3);
    run_batch(1'b1, 3);
    // The last word of the batch is still being read out; let it leave first.
    wait_drained();
    // Nobody drains: four words fill the queue and the fifth waits on the link.
    result_ready = 1'b0;
    run_batch(1'($urandom), 5);
    repeat (300) @(posedge clk);
    #1;
    check_bit(result_valid, 1'b1);
    check_bit(link.rd_n, 1'b0);
    check_bit(link.cs_n, 1'b0);
    rnd_ready = 1'b1;
    wait_drained();
    rnd_ready = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    check_bit(result_valid, 1'b0);
    check_bit(link.busy, 1'b0);
    stop_test();
  end
endmodule : tb_sar_adc_parallel_readout

`default_nettype wire
